// file: inc/tjmd_pkg.sv
// constants, pointer type and gray helpers for the tributary mapper/demapper
// assumes a 40 MHz system clock and one aggregate link clock
//
// What this block does
// [RL1] demapper extracts one tributary from aggregate payload
// [RL2] majority zero control bits: opportunity bit is data
// [RL3] majority one control bits: opportunity bit discarded
// [RL4] demapper store written by gapped payload clock
// [RL5] store read by smoothed clock tracking far rate
// [RL6] output jitter within quarter unit interval
// [RL7] demapper store deep enough for rate offsets
// [RL8] recovers bit-error-free soon after frequency step
// [RL9] demapper works on one slot, index one..four
// [RL10] inactive demapper sends all ones, no status
// [RL11] all-ones and server fail follow trail fail
// [RL12] normal data resumes promptly when insertion clears
// [RL13] mapper inserts tributary into chosen aggregate slot
// [RL14] mapper store written by tributary input clock
// [RL15] mapper store read by aggregate timing and frame
// [RL16] positive justification skips one read, empty opportunity
// [RL17] mapper emits three-bit justification control code
// [RL18] mapper store absorbs offsets and frequency steps
// [RL19] mapper writes only its own selected slot
// [RL20] mapper drives slot only while activated
// [RL21] positions found by counting from frame start
package tjmd_pkg;
  localparam int SET_BITS = 384;
  localparam int FAS_BITS = 12;
  localparam int CTRL_BITS = 4;
  localparam int JUST_END = 8;
  localparam int LAST_SET = 3;
  localparam int SLOT_CAPACITY = 381;
  localparam int STORE_DEPTH = 32;
  localparam int PTR_W = $clog2(STORE_DEPTH) + 1;
  localparam int TRIB_RATE_KHZ = 8448;
  localparam int CLK_RATE_KHZ = 40000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int NCO_BITS = 24;
  localparam int NCO_GAIN_SHIFT = 6;
  localparam logic [NCO_BITS-1:0] NCO_NOMINAL_STEP =
    NCO_BITS'((64'(TRIB_RATE_KHZ) << NCO_BITS) / 64'(CLK_RATE_KHZ));
  localparam int AIS_RESPONSE_US = 800;
  // longest time, so rounded down
  localparam int AIS_RESPONSE_CYCLES = (AIS_RESPONSE_US * 1000) / CLK_PERIOD_NS;

  typedef logic [PTR_W-1:0] ptr_t;

  function automatic ptr_t to_gray(ptr_t b);
    return b ^ (b >> 1);
  endfunction

  function automatic ptr_t from_gray(ptr_t g);
    ptr_t b;
    b = g;
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction
endpackage

// file: verif/agg_frame_source.sv
// far-end aggregate frame source: free-running frames of 4 sets x 384 bits
// assumes the link clock runs free and the design samples on its rising edge
`timescale 1ns/1ps

module agg_frame_source (
  input wire logic i_link_clk,
  input wire logic i_nrst,
  input wire logic i_payload_bit,
  input wire logic i_opportunity_bit,
  input wire logic i_stuff,
  output logic o_frame_start,
  output logic o_data,
  output logic [10:0] o_pos
);
  logic [10:0] pos_q;
  logic [1:0] set_w;
  logic [8:0] bit_w;
  logic ovh_w;
  logic ctrl_w;
  logic opp_w;
  assign set_w = 2'(pos_q / 11'd384);
  assign bit_w = 9'(pos_q % 11'd384);
  assign ovh_w = (set_w == 2'h0) && (bit_w < 9'h00c);
  assign ctrl_w = (set_w != 2'h0) && (bit_w < 9'h004);
  assign opp_w = (set_w == 2'h3) && (bit_w >= 9'h004) && (bit_w < 9'h008);
  // reset value puts the first frame start 3 link edges after release
  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pos_q <= 11'h5fd;
    end else begin
      pos_q <= (pos_q == 11'h5ff) ? 11'h000 : pos_q + 11'h001;
    end
  end
  assign o_frame_start = i_nrst && (pos_q == 11'h000);
  assign o_pos = pos_q;
  // same code in all three sets, as a far-end mapper sends it
  // overhead content is arbitrary, it alternates so it never looks idle
  assign o_data = ovh_w ? bit_w[0] :
                  ctrl_w ? i_stuff :
                  opp_w ? i_opportunity_bit : i_payload_bit;
endmodule

// file: verif/tributary_justification_mapper_demapper_test.sv
// self-checking bench for the tributary slot mapper/demapper
// assumes the design package is compiled first; slot 2 is exercised
`timescale 1ns/1ps

module tributary_justification_mapper_demapper_test;
  import tjmd_pkg::*;
  localparam int unsigned SLOT = 2;
  logic i_clk = 1'b0;
  logic lclk = 1'b0;
  logic i_nrst = 1'b0;
  logic tsf = 1'b0, dem_act = 1'b0, map_act = 1'b0;
  logic trib_clk = 1'b0, trib_data = 1'b0;
  logic pay = 1'b0, opp = 1'b1, stuff = 1'b1;
  logic fs, agg_d, o_agg_d, o_drive, o_rdata, o_rclk, o_fail;
  logic [10:0] pos;
  int acc = 0, cyc = 0, n_fail = 0, n_checks = 0;

  initial forever #12.5 i_clk = ~i_clk;
  initial begin
    #3;
    forever #7.5 lclk = ~lclk;
  end

  // tributary clock of 8448 kHz made by an accumulator on the system clock
  always @(posedge i_clk) begin
    if (acc + 16896 >= 40000) begin
      acc <= acc + 16896 - 40000;
      trib_clk <= ~trib_clk;
      if (trib_clk) trib_data <= ~trib_data;
    end else begin
      acc <= acc + 16896;
    end
  end

  agg_frame_source agg_frame_source_inst (
    .i_link_clk(lclk), .i_nrst(i_nrst), .i_payload_bit(pay),
    .i_opportunity_bit(opp), .i_stuff(stuff),
    .o_frame_start(fs), .o_data(agg_d), .o_pos(pos));

  tributary_justification_mapper_demapper #(.SLOT(SLOT), .AIS_RESPONSE_CYCLES(100))
    tributary_justification_mapper_demapper_inst (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_aggregate_frame_clock(lclk),
    .i_aggregate_frame_data(agg_d), .i_aggregate_frame_start(fs),
    .i_aggregate_trail_signal_fail(tsf), .i_aggregate_timing_frame_start(fs),
    .i_demapper_activate(dem_act), .i_mapper_activate(map_act),
    .i_incoming_tributary_clock(trib_clk), .i_incoming_tributary_data(trib_data),
    .o_aggregate_frame_data(o_agg_d), .o_aggregate_frame_drive(o_drive),
    .o_recovered_tributary_data(o_rdata), .o_recovered_tributary_clock(o_rclk),
    .o_tributary_server_fail_out(o_fail));

  task automatic chk(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: %s got %b", $time, msg, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic wait_frame();
    do @(posedge lclk); while (pos !== 11'h000);
  endtask

  task automatic clks(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic t_reset();
    #40;
    chk(o_agg_d, 1'b1, "agg data in reset");
    chk(o_drive, 1'b0, "drive in reset");
    chk(o_rdata, 1'b1, "trib data in reset");
    chk(o_rclk, 1'b0, "trib clock in reset");
    chk(o_fail, 1'b0, "fail in reset");
  endtask

  // slot ownership across one frame, then released
  task automatic t_mapper();
    int q, n_drv;
    logic ctl1;
    @(posedge i_clk) map_act <= 1'b1;
    wait_frame();
    wait_frame();
    n_drv = 0;
    repeat (1536) begin
      @(negedge lclk);
      q = (int'(pos) + 1535) % 1536;
      chk(o_drive, (q % 4 == SLOT - 1) && !(q < 12), "slot drive");
      if (o_drive === 1'b1) n_drv++;
      if (q == 384 + SLOT - 1) ctl1 = o_agg_d;
      if (q == 768 + SLOT - 1 || q == 1152 + SLOT - 1)
        chk(o_agg_d, ctl1, "control code bits differ");
    end
    n_checks++;
    if (n_drv != SLOT_CAPACITY) begin
      n_fail++;
      $display("MISMATCH at %0t: driven bits %0d", $time, n_drv);
    end
    @(posedge i_clk) map_act <= 1'b0;
    wait_frame();
    repeat (1536) begin
      @(negedge lclk);
      chk(o_drive, 1'b0, "drive while inactive");
    end
  endtask

  // zero payload with one-valued opportunity bits; recovered clock rate counted too
  task automatic t_demap(input logic st);
    int ones, rises, exp_r;
    logic prv;
    @(posedge i_clk) stuff <= st;
    wait_frame();
    wait_frame();
    ones = 0;
    rises = 0;
    exp_r = 3000 * TRIB_RATE_KHZ / CLK_RATE_KHZ;
    prv = o_rclk;
    repeat (3000) begin
      clks(1);
      if (o_rdata === 1'b1) ones++;
      if (o_rclk === 1'b1 && prv === 1'b0) rises++;
      prv = o_rclk;
    end
    n_checks++;
    if (st ? (ones != 0) : (ones == 0)) begin
      n_fail++;
      $display("MISMATCH at %0t: ones seen %0d stuff %b", $time, ones, st);
    end
    n_checks++;
    if (rises < exp_r - 2 || rises > exp_r + 2) begin
      n_fail++;
      $display("MISMATCH at %0t: recovered clock edges %0d", $time, rises);
    end
  endtask

  task automatic t_inactive();
    @(posedge i_clk) begin
      dem_act <= 1'b0;
      tsf <= 1'b1;
    end
    clks(10);
    repeat (500) begin
      clks(1);
      chk(o_rdata, 1'b1, "inactive data");
      chk(o_fail, 1'b0, "inactive status");
    end
    @(posedge i_clk) begin
      dem_act <= 1'b1;
      tsf <= 1'b0;
    end
    clks(10);
  endtask

  task automatic t_tsf();
    int n;
    @(posedge i_clk) tsf <= 1'b1;
    n = 0;
    do begin clks(1); n++; end while (o_fail !== 1'b1 && n < 100);
    chk(o_fail, 1'b1, "fail not raised");
    repeat (400) begin
      clks(1);
      chk(o_rdata, 1'b1, "all ones during fail");
    end
    @(posedge i_clk) tsf <= 1'b0;
    n = 0;
    do begin clks(1); n++; end while (o_fail !== 1'b0 && n < 100);
    chk(o_fail, 1'b0, "fail not cleared");
    n = 0;
    do begin clks(1); n++; end while (o_rdata !== 1'b0 && n < 2000);
    chk(o_rdata, 1'b0, "data not resumed");
  endtask

  initial begin
    t_reset();
    @(posedge i_clk) i_nrst <= 1'b1;
    @(posedge i_clk) dem_act <= 1'b1;
    t_mapper();
    t_demap(1'b1);
    t_demap(1'b0);
    @(posedge i_clk) stuff <= 1'b1;
    t_inactive();
    t_tsf();
    end_sim();
  end
endmodule

// file: verilog/tributary_justification_mapper_demapper.sv
// tributary slot mapper and demapper with positive justification
// assumes frame inputs arrive on the aggregate clock; tributary pins are asynchronous
`timescale 1ns/1ps

module slot_position_decoder #(
  parameter int unsigned SLOT = 1
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_frame_start,
  output logic o_ctrl,
  output logic o_first_ctrl,
  output logic o_just,
  output logic o_data
);
  import tjmd_pkg::*;
  logic [1:0] set_q;
  logic [1:0] set_d;
  logic [1:0] cur_set;
  logic [8:0] bit_q;
  logic [8:0] bit_d;
  logic [8:0] cur_bit;
  logic wrap;
  logic lane_ok;
  logic in_fas;
  logic in_ctrl_row;
  logic in_just_row;

  // position counted from frame start, which marks bit 0 (see [RL21])
  assign cur_set = i_frame_start ? 2'h0 : set_q;
  assign cur_bit = i_frame_start ? 9'h0 : bit_q;
  assign wrap = cur_bit == 9'(SET_BITS - 1);
  assign bit_d = wrap ? 9'h0 : cur_bit + 9'h1;
  assign set_d = wrap ? cur_set + 2'h1 : cur_set;
  // bits interleave four ways; overhead regions are multiples of four (see [RL9])
  assign lane_ok = cur_bit[1:0] == 2'(SLOT - 1);
  assign in_fas = cur_set == 2'h0 && cur_bit < 9'(FAS_BITS);
  assign in_ctrl_row = cur_set != 2'h0 && cur_bit < 9'(CTRL_BITS);
  assign in_just_row = cur_set == 2'(LAST_SET) && cur_bit >= 9'(CTRL_BITS)
                       && cur_bit < 9'(JUST_END);
  assign o_ctrl = lane_ok && in_ctrl_row;
  assign o_first_ctrl = o_ctrl && cur_set == 2'h1;
  assign o_just = lane_ok && in_just_row;
  assign o_data = lane_ok && !in_fas && !in_ctrl_row && !in_just_row;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      set_q <= 2'h0;
      bit_q <= 9'h0;
    end else begin
      set_q <= set_d;
      bit_q <= bit_d;
    end
  end
endmodule

module tributary_justification_mapper_demapper #(
  parameter int unsigned SLOT = 1,
  parameter int AIS_RESPONSE_CYCLES = tjmd_pkg::AIS_RESPONSE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_aggregate_frame_clock,
  input wire logic i_aggregate_frame_data,
  input wire logic i_aggregate_frame_start,
  input wire logic i_aggregate_trail_signal_fail,
  input wire logic i_aggregate_timing_frame_start,
  input wire logic i_demapper_activate,
  input wire logic i_mapper_activate,
  input wire logic i_incoming_tributary_clock,
  input wire logic i_incoming_tributary_data,
  output logic o_aggregate_frame_data,
  output logic o_aggregate_frame_drive,
  output logic o_recovered_tributary_data,
  output logic o_recovered_tributary_clock,
  output logic o_tributary_server_fail_out
);
  import tjmd_pkg::*;

  localparam ptr_t DEPTH_P = ptr_t'(STORE_DEPTH);
  localparam ptr_t HALF_P = ptr_t'(STORE_DEPTH / 2);

  // link-domain reset: asserted at once, released on the link clock
  logic [1:0] lrst_q;
  logic l_nrst;
  always_ff @(posedge i_aggregate_frame_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      lrst_q <= 2'h0;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end
  assign l_nrst = lrst_q[1];

  // mapper, tributary side (system clock)
  logic [2:0] tck_q;
  logic [1:0] tdat_q;
  logic m_mem [STORE_DEPTH];
  ptr_t m_wptr_q;
  ptr_t m_wgray_q;
  ptr_t m_rgray_q;
  ptr_t m_rgray_s1_q;
  ptr_t m_rgray_s2_q;
  logic m_wr_full;
  logic m_wr_en;

  // tributary clock is oversampled; its rising edge strobes one bit in
  assign m_wr_full = (m_wptr_q - from_gray(m_rgray_s2_q)) == DEPTH_P;
  assign m_wr_en = tck_q[1] && !tck_q[2] && !m_wr_full; // see [RL14] see [RL18]

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tck_q <= 3'h0;
      tdat_q <= 2'h0;
      m_wptr_q <= '0;
      m_wgray_q <= '0;
      m_rgray_s1_q <= '0;
      m_rgray_s2_q <= '0;
    end else begin
      tck_q <= {tck_q[1:0], i_incoming_tributary_clock};
      tdat_q <= {tdat_q[0], i_incoming_tributary_data};
      m_rgray_s1_q <= m_rgray_q;
      m_rgray_s2_q <= m_rgray_s1_q;
      m_wptr_q <= m_wr_en ? m_wptr_q + ptr_t'(1) : m_wptr_q;
      m_wgray_q <= to_gray(m_wptr_q);
    end
  end

  always_ff @(posedge i_clk) begin
    if (m_wr_en) begin
      m_mem[m_wptr_q[PTR_W-2:0]] <= tdat_q[1];
    end
  end

  // mapper, aggregate side (link clock)
  logic m_ctrl;
  logic m_first;
  logic m_just;
  logic m_data;
  ptr_t m_rptr_q;
  ptr_t m_wgray_s1_q;
  ptr_t m_wgray_s2_q;
  logic [1:0] m_act_q;
  logic m_stuff_q;
  ptr_t m_fill;
  logic m_empty;
  logic m_stuff_now;
  logic m_rd_en;
  logic m_out_bit;
  logic m_hit;

  slot_position_decoder #(.SLOT(SLOT)) u_map_pos (
    .i_clk(i_aggregate_frame_clock),
    .i_nrst(l_nrst),
    .i_frame_start(i_aggregate_timing_frame_start),
    .o_ctrl(m_ctrl),
    .o_first_ctrl(m_first),
    .o_just(m_just),
    .o_data(m_data)
  );

  assign m_fill = from_gray(m_wgray_s2_q) - m_rptr_q;
  assign m_empty = m_fill == '0;
  // decision taken once per frame at the first control bit; a thin store stuffs
  assign m_stuff_now = m_first ? (m_fill < HALF_P) : m_stuff_q;
  assign m_rd_en = m_act_q[1] && (m_data || (m_just && !m_stuff_q)) && !m_empty; // see [RL15] see [RL16]
  assign m_out_bit = m_ctrl ? m_stuff_now : (m_rd_en ? m_mem[m_rptr_q[PTR_W-2:0]] : 1'b1); // see [RL17]
  assign m_hit = m_ctrl || m_just || m_data;

  always_ff @(posedge i_aggregate_frame_clock or negedge l_nrst) begin
    if (!l_nrst) begin
      m_act_q <= 2'h0;
      m_wgray_s1_q <= '0;
      m_wgray_s2_q <= '0;
      m_rptr_q <= '0;
      m_rgray_q <= '0;
      m_stuff_q <= 1'b0;
      o_aggregate_frame_data <= 1'b1;
      o_aggregate_frame_drive <= 1'b0;
    end else begin
      m_act_q <= {m_act_q[0], i_mapper_activate};
      m_wgray_s1_q <= m_wgray_q;
      m_wgray_s2_q <= m_wgray_s1_q;
      m_rptr_q <= m_rd_en ? m_rptr_q + ptr_t'(1) : m_rptr_q;
      m_rgray_q <= to_gray(m_rptr_q);
      m_stuff_q <= m_stuff_now;
      o_aggregate_frame_data <= m_out_bit; // see [RL13]
      o_aggregate_frame_drive <= m_act_q[1] && m_hit; // see [RL19] see [RL20]
    end
  end

  // demapper, aggregate side (link clock)
  logic d_ctrl;
  logic d_first;
  logic d_just;
  logic d_data;
  logic [1:0] d_votes_q;
  logic [1:0] d_votes_d;
  logic d_maj;
  logic d_mem [STORE_DEPTH];
  ptr_t d_wptr_q;
  ptr_t d_wgray_q;
  ptr_t d_rgray_q;
  ptr_t d_rgray_s1_q;
  ptr_t d_rgray_s2_q;
  logic d_full;
  logic d_wr_en;

  slot_position_decoder #(.SLOT(SLOT)) u_dem_pos (
    .i_clk(i_aggregate_frame_clock),
    .i_nrst(l_nrst),
    .i_frame_start(i_aggregate_frame_start),
    .o_ctrl(d_ctrl),
    .o_first_ctrl(d_first),
    .o_just(d_just),
    .o_data(d_data)
  );

  assign d_votes_d = d_first ? {1'b0, i_aggregate_frame_data}
                   : (d_ctrl ? d_votes_q + {1'b0, i_aggregate_frame_data} : d_votes_q);
  assign d_maj = d_votes_q >= 2'h2; // see [RL2] see [RL3]
  assign d_full = (d_wptr_q - from_gray(d_rgray_s2_q)) == DEPTH_P; // see [RL7]
  // gapped write: payload bits, plus the opportunity bit only when it carries data
  assign d_wr_en = (d_data || (d_just && !d_maj)) && !d_full; // see [RL1] see [RL4]

  always_ff @(posedge i_aggregate_frame_clock or negedge l_nrst) begin
    if (!l_nrst) begin
      d_votes_q <= 2'h0;
      d_wptr_q <= '0;
      d_wgray_q <= '0;
      d_rgray_s1_q <= '0;
      d_rgray_s2_q <= '0;
    end else begin
      d_votes_q <= d_votes_d;
      d_wptr_q <= d_wr_en ? d_wptr_q + ptr_t'(1) : d_wptr_q;
      d_wgray_q <= to_gray(d_wptr_q);
      d_rgray_s1_q <= d_rgray_q;
      d_rgray_s2_q <= d_rgray_s1_q;
    end
  end

  always_ff @(posedge i_aggregate_frame_clock) begin
    if (d_wr_en) begin
      d_mem[d_wptr_q[PTR_W-2:0]] <= i_aggregate_frame_data;
    end
  end

  // demapper, tributary side (system clock)
  ptr_t d_rptr_q;
  ptr_t d_wgray_s1_q;
  ptr_t d_wgray_s2_q;
  logic [1:0] d_tsf_q;
  logic [1:0] d_act_q;
  ptr_t d_fill;
  logic d_empty;
  logic signed [PTR_W:0] d_err;
  logic [NCO_BITS-1:0] d_step;
  logic [NCO_BITS-1:0] d_acc_q;
  logic [NCO_BITS:0] d_acc_d;
  logic d_carry;
  logic d_rd_en;
  logic d_rd_bit;
  logic d_force_ones;

  assign d_fill = from_gray(d_wgray_s2_q) - d_rptr_q;
  assign d_empty = d_fill == '0;
  // rate steered by store fill so the read clock follows the far-end tributary;
  // small gain keeps the pull slow and the spacing even (see [RL5] see [RL8])
  assign d_err = $signed({1'b0, d_fill}) - $signed({1'b0, HALF_P});
  assign d_step = NCO_NOMINAL_STEP + NCO_BITS'(d_err <<< NCO_GAIN_SHIFT);
  assign d_acc_d = {1'b0, d_acc_q} + {1'b0, d_step};
  // one read per overflow; 25 ns quantisation stays near 0.21 UI (see [RL6])
  assign d_carry = d_acc_d[NCO_BITS];
  assign d_rd_en = d_carry && !d_empty;
  assign d_rd_bit = d_mem[d_rptr_q[PTR_W-2:0]];
  assign d_force_ones = d_tsf_q[1] || !d_act_q[1]; // see [RL10] see [RL11]

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      d_rptr_q <= '0;
      d_rgray_q <= '0;
      d_wgray_s1_q <= '0;
      d_wgray_s2_q <= '0;
      d_tsf_q <= 2'h0;
      d_act_q <= 2'h0;
      d_acc_q <= '0;
      o_recovered_tributary_data <= 1'b1;
      o_recovered_tributary_clock <= 1'b0;
      o_tributary_server_fail_out <= 1'b0;
    end else begin
      d_wgray_s1_q <= d_wgray_q;
      d_wgray_s2_q <= d_wgray_s1_q;
      d_tsf_q <= {d_tsf_q[0], i_aggregate_trail_signal_fail};
      d_act_q <= {d_act_q[0], i_demapper_activate};
      d_acc_q <= d_acc_d[NCO_BITS-1:0];
      d_rptr_q <= d_rd_en ? d_rptr_q + ptr_t'(1) : d_rptr_q;
      d_rgray_q <= to_gray(d_rptr_q);
      o_recovered_tributary_clock <= d_acc_d[NCO_BITS-1];
      // store keeps draining under all-ones so data resumes at once (see [RL12])
      if (d_force_ones) begin
        o_recovered_tributary_data <= 1'b1;
      end else if (d_rd_en) begin
        o_recovered_tributary_data <= d_rd_bit;
      end
      o_tributary_server_fail_out <= d_tsf_q[1] && d_act_q[1]; // see [RL11]
    end
  end

  // checking
  int ais_wait_q;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ais_wait_q <= 0;
    end else begin
      ais_wait_q <= (d_force_ones && !o_recovered_tributary_data) ? ais_wait_q + 1 : 0;
    end
  end

  sequence s_three_ctrl_seen;
    d_first ##[1:800] d_ctrl ##[1:800] d_ctrl;
  endsequence

  property p_inactive_ones;
    @(posedge i_clk) disable iff (!i_nrst)
    !d_act_q[1] |=> o_recovered_tributary_data && !o_tributary_server_fail_out;
  endproperty
  a_inactive_ones: assert property (p_inactive_ones) else $error("inactive not all ones"); // see [RL10]

  property p_ssf_follows;
    @(posedge i_clk) disable iff (!i_nrst)
    (d_tsf_q[1] && d_act_q[1]) |=> o_tributary_server_fail_out && o_recovered_tributary_data;
  endproperty
  a_ssf_follows: assert property (p_ssf_follows) else $error("fail not followed"); // see [RL11]

  property p_ais_bound;
    @(posedge i_clk) disable iff (!i_nrst)
    ais_wait_q < AIS_RESPONSE_CYCLES;
  endproperty
  a_ais_bound: assert property (p_ais_bound) else $error("all ones too late"); // see [RL11]

  property p_resume;
    @(posedge i_clk) disable iff (!i_nrst)
    (!d_force_ones && d_rd_en) |=> o_recovered_tributary_data == $past(d_rd_bit);
  endproperty
  a_resume: assert property (p_resume) else $error("recovered bit not delivered"); // see [RL12]

  property p_even_clock;
    @(posedge i_clk) disable iff (!i_nrst)
    d_carry |=> !d_carry [*3] ##1 (d_carry or (!d_carry ##1 d_carry));
  endproperty
  a_even_clock: assert property (p_even_clock) else $error("read clock uneven"); // see [RL5]

  property p_stuff_skips;
    @(posedge i_aggregate_frame_clock) disable iff (!l_nrst)
    (m_just && m_stuff_q) |-> !m_rd_en ##1 o_aggregate_frame_data;
  endproperty
  a_stuff_skips: assert property (p_stuff_skips) else $error("stuff bit read store"); // see [RL16]

  property p_ctrl_code;
    @(posedge i_aggregate_frame_clock) disable iff (!l_nrst)
    (m_ctrl && !m_first) |=> o_aggregate_frame_data == $past(m_stuff_q);
  endproperty
  a_ctrl_code: assert property (p_ctrl_code) else $error("control bit wrong"); // see [RL17]

  property p_slot_drive;
    @(posedge i_aggregate_frame_clock) disable iff (!l_nrst)
    o_aggregate_frame_drive |-> $past(m_act_q[1]) && $past(m_hit);
  endproperty
  a_slot_drive: assert property (p_slot_drive) else $error("drove outside slot"); // see [RL19]

  property p_maj_data;
    @(posedge i_aggregate_frame_clock) disable iff (!l_nrst)
    (s_three_ctrl_seen ##[1:800] d_just) |-> (d_wr_en == (!d_maj && !d_full));
  endproperty
  a_maj_data: assert property (p_maj_data) else $error("opportunity bit misjudged"); // see [RL2]

  property p_maj_stuff;
    @(posedge i_aggregate_frame_clock) disable iff (!l_nrst)
    (d_just && d_maj) |-> !d_wr_en;
  endproperty
  a_maj_stuff: assert property (p_maj_stuff) else $error("stuff bit written"); // see [RL3]
endmodule
